// ---- hw/power_budget_capability.sv ----
// Purpose: Register bank of the power budgeting extended capability
// Assumes: One clock, synchronous active-high reset, simple strobe bus
// Notes: Read data stands one cycle after the read strobe, zero otherwise
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "power_budget_params.svh"
module power_budget_capability #(
    parameter logic [7:0] SUST_BASE = 8'h04,
    parameter logic [1:0] SUST_SCALE = 2'h0,
    parameter logic [2:0] SUST_RAIL = 3'h2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port role strap, same clock domain
    input wire logic is_upstream,
    // Nonvolatile auto-load
    input wire logic load_valid,
    input wire logic [7:0] load_base_power,
    input wire logic load_sys_alloc,
    // Register bus
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    localparam int NUM_REGS = 4;
    localparam int IDX_HEADER = 0;
    localparam int IDX_SELECT = 1;
    localparam int IDX_DATA = 2;
    localparam int IDX_FLAGS = 3;

    // Decode table, one offset per register in index order
    localparam logic [11:0] REG_OFFSET [NUM_REGS] = '{
        `PB_OFF_HEADER,
        `PB_OFF_SELECT,
        `PB_OFF_DATA,
        `PB_OFF_FLAGS
    };

    // Bits software may change, per register
    localparam logic [31:0] WRITE_MASK [NUM_REGS] = '{
        32'h0000_0000,
        32'h0000_00ff,
        32'h0000_0000,
        32'h0000_0000
    };

    // Bits that read back; the rest are reserved and read zero
    localparam logic [31:0] READ_MASK [NUM_REGS] = '{
        32'hffff_ffff,
        32'h0000_00ff,
        32'h001f_ffff,
        32'h0000_0001
    };

    localparam power_budget_pkg::bank_state_t RESET_STATE = '{
        selector: `PB_SEL_RESET,
        base_power: `PB_BASE_RESET,
        sys_alloc: `PB_SYSALLOC_RESET,
        rdata: 32'h0
    };

    // Register state and its next value
    power_budget_pkg::bank_state_t state;
    power_budget_pkg::bank_state_t next_state;

    // Bus request as one carrier
    power_budget_pkg::reg_req_t req;

    // Entry word from the selector mux, and its fields
    power_budget_pkg::budget_word_t word;
    logic [7:0] entry_base;
    logic [1:0] entry_scale;
    logic [2:0] entry_substate;
    logic [1:0] entry_pm_state;
    logic [2:0] entry_kind;
    logic [2:0] entry_rail;

    // Header fields
    logic [15:0] cap_id;
    logic [3:0] cap_ver;
    logic [11:0] next_ptr;
    logic [31:0] header;

    // Read words before and after masking
    logic [31:0] select_word;
    logic [31:0] data_word;
    logic [31:0] flags_word;
    logic [31:0] reg_word [NUM_REGS];
    logic [31:0] masked_word [NUM_REGS];
    logic [31:0] gated_word [NUM_REGS];
    logic [31:0] read_word;

    // Address decode
    logic [NUM_REGS-1:0] hit;
    logic any_hit;
    logic select_write;
    logic [31:0] select_merged;

    // Next value of each field of the state
    logic [7:0] next_selector;
    logic [7:0] next_base_power;
    logic next_sys_alloc;
    logic [31:0] next_rdata;

    budget_entry_mux #(
        .SUST_BASE(SUST_BASE),
        .SUST_SCALE(SUST_SCALE),
        .SUST_RAIL(SUST_RAIL)
    ) u_mux (
        .selector(state.selector),
        .base_power(state.base_power),
        .word(word)
    );

    // Bus request gathered into one carrier
    always_comb begin
        req.addr = addr;
        req.wdata = wdata;
        req.wr = wr;
        req.rd = rd;
    end

    // Header fields; the pointer follows the port role strap
    always_comb begin
        cap_id = `PB_CAP_ID;
        cap_ver = `PB_CAP_VER;
        if (is_upstream) begin
            next_ptr = `PB_NEXT_UP;
        end else begin
            next_ptr = `PB_NEXT_DOWN;
        end
        header = {next_ptr, cap_ver, cap_id};
    end

    // Selector readback, upper bits reserved
    always_comb begin
        select_word = 32'h0;
        select_word[7:0] = state.selector;
    end

    // Entry fields named, then repacked with reserved bits zero
    always_comb begin
        entry_base = word.base_power;
        entry_scale = word.scale;
        entry_substate = word.substate;
        entry_pm_state = word.pm_state;
        entry_kind = word.kind;
        entry_rail = word.rail;
    end

    // Built from the live selector, so a write then read is fresh
    always_comb begin
        data_word = 32'h0;
        data_word[7:0] = entry_base;
        data_word[9:8] = entry_scale;
        data_word[12:10] = entry_substate;
        data_word[14:13] = entry_pm_state;
        data_word[17:15] = entry_kind;
        data_word[20:18] = entry_rail;
    end

    // Allocation flag word
    always_comb begin
        flags_word = 32'h0;
        flags_word[0] = state.sys_alloc;
    end

    // Words in decode order
    always_comb begin
        reg_word[IDX_HEADER] = header;
        reg_word[IDX_SELECT] = select_word;
        reg_word[IDX_DATA] = data_word;
        reg_word[IDX_FLAGS] = flags_word;
    end

    // Decode and gate per register
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        assign hit[g] = (req.addr == REG_OFFSET[g]);
        assign masked_word[g] = reg_word[g] & READ_MASK[g];
        assign gated_word[g] = hit[g] ? masked_word[g] : 32'h0;
    end

    // One-hot decode lets an OR stand in for a wide case
    always_comb begin
        read_word = 32'h0;
        for (int i = 0; i < NUM_REGS; i++) begin
            read_word = read_word | gated_word[i];
        end
    end

    always_comb begin
        any_hit = |hit;
        select_write = req.wr && hit[IDX_SELECT];
    end

    // Only bits under the write mask take bus data
    always_comb begin
        select_merged = select_word & ~WRITE_MASK[IDX_SELECT];
        select_merged = select_merged | (req.wdata & WRITE_MASK[IDX_SELECT]);
    end

    always_comb begin
        next_selector = state.selector;
        if (select_write) begin
            next_selector = select_merged[7:0];
        end
    end

    // Auto-load overrides read-only defaults before software looks
    always_comb begin
        next_base_power = state.base_power;
        next_sys_alloc = state.sys_alloc;
        if (load_valid) begin
            next_base_power = load_base_power;
            next_sys_alloc = load_sys_alloc;
        end
    end

    // Read data stands one cycle, zero otherwise; unmapped reads zero
    always_comb begin
        next_rdata = 32'h0;
        if (req.rd && any_hit) begin
            next_rdata = read_word;
        end
    end

    always_comb begin
        next_state = state;
        next_state.selector = next_selector;
        next_state.base_power = next_base_power;
        next_state.sys_alloc = next_sys_alloc;
        next_state.rdata = next_rdata;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
endmodule
`default_nettype wire

// ---- hw/power_budget_params.svh ----
// Purpose: Offsets, field values, reset values for the power budget block
// Assumes: Byte addresses on a 12-bit config offset
// Notes: Included by bare name
`ifndef POWER_BUDGET_PARAMS_SVH
`define POWER_BUDGET_PARAMS_SVH

`define PB_ADDR_W 12
`define PB_OFF_HEADER 12'h20c
`define PB_OFF_SELECT 12'h210
`define PB_OFF_DATA 12'h214
`define PB_OFF_FLAGS 12'h218

`define PB_CAP_ID 16'h0004
`define PB_CAP_VER 4'h1
`define PB_NEXT_UP 12'h230
`define PB_NEXT_DOWN 12'h220

`define PB_SEL_MAX 8'h00
`define PB_SEL_SUST 8'h01
`define PB_SEL_RESET 8'h00

`define PB_BASE_RESET 8'h04
`define PB_SCALE_RESET 2'h0
`define PB_SUBSTATE_RESET 3'h0
`define PB_PMSTATE_RESET 2'h0
`define PB_TYPE_MAX 3'h7
`define PB_TYPE_SUST 3'h1
`define PB_RAIL_RESET 3'h2
`define PB_SYSALLOC_RESET 1'h0

`endif

// ---- hw/power_budget_pkg.sv ----
// Purpose: Types for the power budget capability block
// Assumes: Nothing
// Notes: Field layout of the budget data word, low bit first at the bottom
package power_budget_pkg;

    typedef struct packed {
        logic [10:0] reserved;
        logic [2:0] rail;
        logic [2:0] kind;
        logic [1:0] pm_state;
        logic [2:0] substate;
        logic [1:0] scale;
        logic [7:0] base_power;
    } budget_word_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] selector;
        logic [7:0] base_power;
        logic sys_alloc;
        logic [31:0] rdata;
    } bank_state_t;

endpackage

// ---- hw/budget_entry_mux.sv ----
// Purpose: Builds the budget data word for the selected entry
// Assumes: Combinational, fed from registers of the bank
// Notes: Sustained entry base power, scale and rail are parameters
`timescale 1ns/1ns
`default_nettype none
`include "power_budget_params.svh"
module budget_entry_mux #(
    parameter logic [7:0] SUST_BASE = 8'h04,
    parameter logic [1:0] SUST_SCALE = 2'h0,
    parameter logic [2:0] SUST_RAIL = 3'h2
) (
    // Selection
    input wire logic [7:0] selector,
    input wire logic [7:0] base_power,
    // Result
    output var power_budget_pkg::budget_word_t word
);
    always_comb begin
        word = '0;
        case (selector)
            `PB_SEL_MAX: begin
                word.base_power = base_power;
                word.scale = `PB_SCALE_RESET;
                word.substate = `PB_SUBSTATE_RESET;
                word.pm_state = `PB_PMSTATE_RESET;
                word.kind = `PB_TYPE_MAX;
                word.rail = `PB_RAIL_RESET;
            end
            `PB_SEL_SUST: begin
                word.base_power = SUST_BASE;
                word.scale = SUST_SCALE;
                word.substate = `PB_SUBSTATE_RESET;
                word.pm_state = `PB_PMSTATE_RESET;
                word.kind = `PB_TYPE_SUST;
                word.rail = SUST_RAIL;
            end
            default: begin
                // Unsupported entry reads as all zero
                word = '0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- dv/budget_checker.sv ----
// Purpose: Port assertions for the power budget bank
// Assumes: rdata stands only in the cycle after rd
// Notes: Selector shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none
module budget_checker (
    // Clock, reset, straps
    input wire logic clk,
    input wire logic rst,
    input wire logic is_upstream,
    input wire logic load_valid,
    input wire logic [7:0] load_base_power,
    input wire logic load_sys_alloc,
    // Bus
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata
);
    logic [7:0] sel;
    wire hr = rd && addr == 12'h20c;
    wire dr = rd && addr == 12'h214;
    always_ff @(posedge clk) begin
        if (rst) sel <= 8'h00;
        else if (wr && addr == 12'h210) sel <= wdata[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    hdr_id_a: assert property (hr |=> rdata[15:0] == 16'h0004) else $error("id");
    hdr_ver_a: assert property (hr |=> rdata[19:16] == 4'h1) else $error("ver");
    next_ptr_a: assert property (hr |=>
        rdata[31:20] == ($past(is_upstream) ? 12'h230 : 12'h220)) else $error("next");
    sel_back_a: assert property (rd && addr == 12'h210 |=>
        rdata == {24'h0, sel}) else $error("sel");
    sel_max_a: assert property (dr && sel == 8'h00 |=>
        rdata[31:8] == 24'h000b80) else $error("max");
    sel_sust_a: assert property (dr && sel == 8'h01 |=>
        {rdata[31:21], rdata[17:10]} == 19'h20) else $error("sust");
    sel_other_a: assert property (dr && sel > 8'h01 |=> rdata == 32'h0) else $error("oth");
    flag_rsvd_a: assert property (rd && addr == 12'h218 |=>
        rdata[31:1] == 31'h0) else $error("flag");
    idle_zero_a: assert property (!rd |=> rdata == 32'h0) else $error("idle");
    cover property (dr && sel == 8'h01);
    cover property (load_valid);
    cover property (hr && !is_upstream);
endmodule
`default_nettype wire

// ---- dv/power_budget_capability_tb.sv ----
// Purpose: Register tests of the power budget bank
// Assumes: Default sustained parameters
// Notes: Reads checked in the cycle after rd
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module power_budget_capability_tb;
    logic clk = 1'h0, rst = 1'h1, is_upstream = 1'h1, load_valid = 1'h0, wr = 1'h0, rd = 1'h0;
    logic load_sys_alloc = 1'h1;
    logic [7:0] load_base_power = 8'h2a;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    int num_errors = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    power_budget_capability dut (.clk, .rst, .is_upstream, .load_valid, .load_base_power,
        .load_sys_alloc, .addr, .wdata, .wr, .rd, .rdata);
    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        `CHK(n, e, rdata)
    endtask
    // Hang guard, tests need well under a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        rreg(12'h20c, 32'h2301_0004, "hdr up");
        rreg(12'h210, 32'h0, "sel");
        rreg(12'h214, 32'h000b_8004, "max");
        rreg(12'h218, 32'h0, "flag");
        rreg(12'h21c, 32'h0, "unmapped");
        $display("reset test done");
        wreg(12'h210, 32'hffff_ff01);
        rreg(12'h214, 32'h0008_8004, "sust");
        for (int i = 2; i < 256; i += 126) begin
            wreg(12'h210, 32'(i));
            rreg(12'h214, 32'h0, "other");
        end
        wreg(12'h20c, 32'hffff_ffff);
        @(posedge clk) is_upstream <= 1'h0;
        rreg(12'h20c, 32'h2201_0004, "hdr down");
        wreg(12'h210, 32'h0);
        @(posedge clk) load_valid <= 1'h1;
        @(posedge clk) load_valid <= 1'h0;
        rreg(12'h214, 32'h000b_802a, "load");
        rreg(12'h218, 32'h1, "load flag");
        $display("select and load test done");
        summarize();
    end
endmodule
bind power_budget_capability budget_checker chk (.clk, .rst, .is_upstream, .load_valid,
    .load_base_power, .load_sys_alloc, .addr, .wdata, .wr, .rd, .rdata);
`default_nettype wire
